/* File: dv/tb_counter_array_pwm16.sv */
// self-checking bench for the sixteen-bit waveform block
`timescale 1ns/10ps
`include "pwm16_consts.svh"
module tb_counter_array_pwm16;
  import pwm16_pkg::*;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, timer0_ovf_i, ext_in_i, ext_clk_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o;
  logic pready_o, pslverr_o, module_output_pin_o, irq_o;
  logic [32:0] exp_q[$];
  logic [15:0] c1, c2, cnt;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;

  counter_array_pwm16 i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .timer0_ovf_i(timer0_ovf_i), .ext_in_i(ext_in_i), .ext_clk_i(ext_clk_i),
    .module_output_pin_o(module_output_pin_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // read monitor: oldest note against each completed read
  always @(posedge clk_i) begin
    cyc++;
    if (psel_i && penable_i && pready_o && !pwrite_i && exp_q.size() > 0) begin
      chk({pslverr_o, prdata_o}, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // unused tick sources toggle randomly so sixteen-bit timing must ignore them
  always @(posedge clk_i) begin
    ext_in_i <= 1'($urandom);
    ext_clk_i <= 1'($urandom);
    timer0_ovf_i <= 1'($urandom);
  end

  task automatic apb(input logic w, input logic [7:0] ofs, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {22'h0, ofs, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    apb(1'b1, ofs, d);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] d, input logic err = 1'b0);
    exp_q.push_back({err, 24'h0, d});
    apb(1'b0, ofs, 8'h00);
  endtask

  // counter jumps near wrap so a period fits in a few hundred cycles
  task automatic jump;
    wr(`OFS_COUNT_LO, 8'h00);
    wr(`OFS_COUNT_HI, 8'hff);
  endtask

  task automatic meas(input logic [15:0] e);
    cnt = 16'h0;
    while (module_output_pin_o !== 1'b1 && cnt < 16'd1000) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    cnt = 16'h0;
    while (module_output_pin_o === 1'b1 && cnt < 16'd1000) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    chk({17'h0, cnt}, {17'h0, e});
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, timer0_ovf_i, ext_in_i, ext_clk_i, nrst_i} = 7'h00;
    paddr_i = 32'h0000_0000;
    pwdata_i = 32'h0000_0000;
    void'($urandom(32'h67ee));
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`OFS_CTRL_FLAGS, 8'h00);
    rd(`OFS_MODE, 8'h00);
    wr(`OFS_CTRL_FLAGS, 8'h38);
    rd(`OFS_CTRL_FLAGS, 8'h00);
    rd(8'hd0, 8'h00, 1'b1);
    $display("register test done");
    c1 = 16'hfff2 + 16'($urandom % 12);
    c2 = c1 - 16'h0003;
    wr(`OFS_MODE, 8'h8b);
    wr(`OFS_WAVE_CFG, 8'h80);
    wr(`OFS_CMP_LO, c1[7:0]);
    wr(`OFS_CMP_HI, c1[15:8]);
    rd(`OFS_CMP_HI, c1[15:8]);
    wr(`OFS_WAVE_CFG, 8'h07);
    wr(`OFS_CMP_LO, c1[7:0]);
    rd(`OFS_MODE, 8'h8b);
    wr(`OFS_CMP_HI, c1[15:8]);
    rd(`OFS_MODE, 8'hcb);
    wr(`OFS_TIMEBASE, {4'h0, TB_SYS, 1'b1});
    jump();
    wr(`OFS_CTRL_FLAGS, 8'h40);
    meas(16'h0 - c1);
    rd(`OFS_CTRL_FLAGS, 8'hc1);
    chk({32'h0, irq_o}, 33'h1);
    wr(`OFS_CTRL_FLAGS, 8'h40);
    rd(`OFS_CTRL_FLAGS, 8'h40);
    chk({32'h0, irq_o}, 33'h0);
    $display("waveform test done");
    // shadow written mid-period must wait for the next overflow
    wr(`OFS_WAVE_CFG, 8'h80);
    wr(`OFS_CMP_LO, c2[7:0]);
    wr(`OFS_CMP_HI, c2[15:8]);
    wr(`OFS_WAVE_CFG, 8'h00);
    rd(`OFS_CMP_LO, c1[7:0]);
    jump();
    meas(16'h0 - c1);
    jump();
    meas(16'h0 - c2);
    $display("reload test done");
    // a lone low-byte compare write clears the compare enable, so the pin stays low
    wr(`OFS_CTRL_FLAGS, 8'h40);
    jump();
    cnt = 16'h0;
    while (irq_o !== 1'b1 && cnt < 16'd1000) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    chk({32'h0, irq_o}, 33'h1);
    wr(`OFS_CMP_LO, c2[7:0]);
    jump();
    cnt = 16'h0;
    repeat (300) begin
      @(posedge clk_i);
      #1;
      if (module_output_pin_o !== 1'b0) cnt++;
    end
    chk({17'h0, cnt}, 33'h0);
    wr(`OFS_CTRL_FLAGS, 8'h00);
    wr(`OFS_COUNT_LO, 8'h34);
    wr(`OFS_COUNT_HI, 8'h12);
    repeat (20) @(posedge clk_i);
    rd(`OFS_COUNT_LO, 8'h34);
    rd(`OFS_COUNT_HI, 8'h12);
    $display("stop test done");
    wr(`OFS_TIMEBASE, {4'h0, TB_DIV4, 1'b0});
    wr(`OFS_COUNT_HI, 8'h00);
    wr(`OFS_COUNT_LO, 8'h00);
    wr(`OFS_CTRL_FLAGS, 8'h40);
    // forty cycles of run hold ten ticks whatever the divider phase
    repeat (37) @(posedge clk_i);
    wr(`OFS_CTRL_FLAGS, 8'h00);
    rd(`OFS_COUNT_LO, 8'h0a);
    rd(`OFS_COUNT_HI, 8'h00);
    $display("timebase test done");
    tally_and_finish();
  end
endmodule

/* File: rtl/counter_array_pwm16.sv */
// apb slave, 16-bit counter and one sixteen-bit waveform module
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "pwm16_consts.svh"
module counter_array_pwm16 (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // timebase sources
  input wire logic timer0_ovf_i,
  input wire logic ext_in_i,
  input wire logic ext_clk_i,
  // outputs
  output logic module_output_pin_o,
  output logic irq_o
);
  import pwm16_pkg::*;

  logic [7:0] ctrl_q, ctrl_d, mode_q, mode_d, wcfg_q, wcfg_d, tb_q, tb_d;
  logic [15:0] cnt_q, cnt_d, cmp_q, cmp_d, shadow_q, shadow_d;
  logic pin_q, pin_d;
  logic [3:0] div_q, div_d;
  logic [1:0] in_s_q, clk_s_q;
  logic in_prev_q, clk_prev_q;
  logic [2:0] ext_div_q, ext_div_d;
  logic tick, wr, rd, ovf, match, wave_mode, mapped;
  logic [7:0] a;
  logic [7:0] rdat;
  logic [31:0] prdata_q, prdata_d;
  timebase_t tb_sel;

  function automatic logic div_hit(input logic [3:0] v, input logic [3:0] lim);
    div_hit = (v >= lim);
  endfunction

  assign a = paddr_i[9:2];
  // unmapped writes are dropped, not aliased
  assign wr = psel_i & penable_i & pwrite_i & mapped;
  // read launched in setup so that read data leaves a flop
  assign rd = psel_i & ~penable_i & ~pwrite_i;
  assign tb_sel = timebase_t'(tb_q[`TB_SEL_LSB +: 3]);
  assign pready_o = 1'b1;
  assign mapped = (a >= `OFS_CTRL_FLAGS) && (a <= `OFS_COUNT_HI) && (paddr_i[1:0] == 2'b00);
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // pins cross two flip-flops before use
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      in_s_q <= 2'b11;
      clk_s_q <= 2'b00;
      in_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
    end else begin
      in_s_q <= {in_s_q[0], ext_in_i};
      clk_s_q <= {clk_s_q[0], ext_clk_i};
      in_prev_q <= in_s_q[1];
      clk_prev_q <= clk_s_q[1];
    end
  end

  // timebase tick select
  always_comb begin
    div_d = div_q + 4'h1;
    ext_div_d = ext_div_q;
    if (clk_s_q[1] & ~clk_prev_q) begin
      ext_div_d = ext_div_q + 3'h1;
    end
    tick = 1'b0;
    unique case (timebase_t'(tb_q[`TB_SEL_LSB +: 3]))
      TB_DIV12: tick = div_hit(div_q, `DIV12);
      TB_DIV4: tick = div_hit(div_q, `DIV4);
      TB_T0: tick = timer0_ovf_i;
      TB_FALL: tick = in_prev_q & ~in_s_q[1];
      TB_SYS: tick = 1'b1;
      TB_EXT8: tick = (clk_s_q[1] & ~clk_prev_q) & (ext_div_q == 3'h7);
      default: tick = 1'b0;
    endcase
    if (div_hit(div_q, `DIV12) ||
        (timebase_t'(tb_q[`TB_SEL_LSB +: 3]) == TB_DIV4 && div_hit(div_q, `DIV4))) begin
      div_d = 4'h0;
    end
  end

  // counter, compare, pin and registers
  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    wcfg_d = wcfg_q;
    tb_d = tb_q;
    cnt_d = cnt_q;
    cmp_d = cmp_q;
    shadow_d = shadow_q;
    pin_d = pin_q;
    // low time only depends on 16-bit compare, no 8..15 bit length field used
    wave_mode = mode_q[`MODE_CMP_EN_BIT] & mode_q[`MODE_WAVE_BIT] &
                mode_q[`MODE_SIXTEEN_BIT];
    ovf = ctrl_q[`CTRL_RUN_BIT] & tick & (cnt_q == 16'hffff);
    match = ctrl_q[`CTRL_RUN_BIT] & tick & (cnt_q + 16'h0001 == cmp_q) &
            mode_q[`MODE_CMP_EN_BIT];
    // software clear first so a same-cycle hardware set wins
    if (wr && a == `OFS_CTRL_FLAGS) begin
      ctrl_d = (ctrl_q & ~`CTRL_WMASK) | (pwdata_i[7:0] & `CTRL_WMASK);
    end
    if (wr && a == `OFS_TIMEBASE) begin
      tb_d = {4'h0, pwdata_i[3:0]};
    end
    if (wr && a == `OFS_WAVE_CFG) begin
      wcfg_d = {pwdata_i[7], 7'h00};
    end
    if (wr && a == `OFS_MODE) begin
      mode_d = pwdata_i[7:0];
    end
    if (wr && a == `OFS_CMP_LO) begin
      if (wcfg_q[`WCFG_RELOAD_BIT]) begin
        shadow_d[7:0] = pwdata_i[7:0];
      end else begin
        cmp_d[7:0] = pwdata_i[7:0];
      end
      mode_d[`MODE_CMP_EN_BIT] = 1'b0;
    end
    if (wr && a == `OFS_CMP_HI) begin
      if (wcfg_q[`WCFG_RELOAD_BIT]) begin
        shadow_d[15:8] = pwdata_i[7:0];
      end else begin
        cmp_d[15:8] = pwdata_i[7:0];
      end
      mode_d[`MODE_CMP_EN_BIT] = 1'b1;
    end
    if (ctrl_q[`CTRL_RUN_BIT] && tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (wr && a == `OFS_COUNT_LO) begin
      cnt_d[7:0] = pwdata_i[7:0];
    end
    if (wr && a == `OFS_COUNT_HI) begin
      cnt_d[15:8] = pwdata_i[7:0];
    end
    if (ovf) begin
      ctrl_d[`CTRL_OVF_BIT] = 1'b1;
      if (wave_mode) begin
        cmp_d = shadow_q;
      end
    end
    if (match && mode_q[`MODE_MATCH_BIT]) begin
      ctrl_d[`CTRL_FLAG_BIT] = 1'b1;
    end
    if (!mode_q[`MODE_CMP_EN_BIT]) begin
      pin_d = 1'b0;
    end else if (wave_mode) begin
      // compare 0 matches at the wrap too, so the pin stays high: 100%
      if (match) begin
        pin_d = 1'b1;
      end else if (ovf) begin
        pin_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= `CTRL_RESET;
      mode_q <= `MODE_RESET;
      wcfg_q <= 8'h00;
      tb_q <= 8'h00;
      cnt_q <= 16'h0000;
      cmp_q <= 16'h0000;
      shadow_q <= 16'h0000;
      pin_q <= 1'b0;
      div_q <= 4'h0;
      ext_div_q <= 3'h0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      wcfg_q <= wcfg_d;
      tb_q <= tb_d;
      cnt_q <= cnt_d;
      cmp_q <= cmp_d;
      shadow_q <= shadow_d;
      pin_q <= pin_d;
      div_q <= div_d;
      ext_div_q <= ext_div_d;
      prdata_q <= prdata_d;
    end
  end

  // read mux; reads of compare follow reload_select
  always_comb begin
    rdat = 8'h00;
    unique case (a)
      `OFS_CTRL_FLAGS: rdat = ctrl_q & `CTRL_WMASK;
      `OFS_TIMEBASE: rdat = tb_q;
      `OFS_MODE: rdat = mode_q;
      `OFS_CMP_LO: rdat = wcfg_q[`WCFG_RELOAD_BIT] ? shadow_q[7:0] : cmp_q[7:0];
      `OFS_CMP_HI: rdat = wcfg_q[`WCFG_RELOAD_BIT] ? shadow_q[15:8] : cmp_q[15:8];
      `OFS_WAVE_CFG: rdat = wcfg_q;
      `OFS_COUNT_LO: rdat = cnt_q[7:0];
      `OFS_COUNT_HI: rdat = cnt_q[15:8];
      default: rdat = 8'h00;
    endcase
    // value is one cycle old; zero again after the access phase
    prdata_d = 32'h0000_0000;
    if (rd && mapped) begin
      prdata_d = {24'h00_0000, rdat};
    end
  end

  assign prdata_o = prdata_q;
  assign module_output_pin_o = pin_q;
  assign irq_o = (ctrl_q[`CTRL_OVF_BIT] & tb_q[`TB_IRQ_EN_BIT]) |
                 (ctrl_q[`CTRL_FLAG_BIT] & mode_q[`MODE_IRQ_EN_BIT]);

  // assertions
  property p_high_on_match;
    @(posedge clk_i) disable iff (!nrst_i)
      (wave_mode && match && mode_q[`MODE_CMP_EN_BIT]) |=> module_output_pin_o;
  endproperty
  a_high_on_match: assert property (p_high_on_match) else $error("pin not high after match");
  property p_low_on_ovf;
    @(posedge clk_i) disable iff (!nrst_i)
      (wave_mode && ovf && !match) |=> !module_output_pin_o;
  endproperty
  a_low_on_ovf: assert property (p_low_on_ovf) else $error("pin not low after overflow");
  property p_ovf_flag;
    @(posedge clk_i) disable iff (!nrst_i) ovf |=> ctrl_q[`CTRL_OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");
  property p_ovf_sticky;
    @(posedge clk_i) disable iff (!nrst_i)
      (ctrl_q[`CTRL_OVF_BIT] && !(wr && a == `OFS_CTRL_FLAGS)) |=> ctrl_q[`CTRL_OVF_BIT];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
  property p_lo_clears_en;
    @(posedge clk_i) disable iff (!nrst_i)
      (wr && a == `OFS_CMP_LO) |=> !mode_q[`MODE_CMP_EN_BIT];
  endproperty
  a_lo_clears_en: assert property (p_lo_clears_en) else $error("enable not cleared");
  property p_hi_sets_en;
    @(posedge clk_i) disable iff (!nrst_i)
      (wr && a == `OFS_CMP_HI) |=> mode_q[`MODE_CMP_EN_BIT];
  endproperty
  a_hi_sets_en: assert property (p_hi_sets_en) else $error("enable not set");
  property p_zero_duty;
    @(posedge clk_i) disable iff (!nrst_i)
      (!mode_q[`MODE_CMP_EN_BIT]) [*2] |-> !module_output_pin_o;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin high while disabled");
  property p_stopped;
    @(posedge clk_i) disable iff (!nrst_i)
      (!ctrl_q[`CTRL_RUN_BIT] && !(wr && a[7:1] == 7'h6f)) |=> $stable(cnt_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");
  property p_reserved;
    @(posedge clk_i) disable iff (!nrst_i) ctrl_q[5:3] == 3'b000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_irq_ovf;
    @(posedge clk_i) disable iff (!nrst_i)
      (ctrl_q[`CTRL_OVF_BIT] && tb_q[`TB_IRQ_EN_BIT]) |-> irq_o;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request missing");
  property p_match_flag;
    @(posedge clk_i) disable iff (!nrst_i)
      (match && mode_q[`MODE_MATCH_BIT]) |=> ctrl_q[`CTRL_FLAG_BIT];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("event flag not set");
  property p_flag_sticky;
    @(posedge clk_i) disable iff (!nrst_i)
      (ctrl_q[`CTRL_FLAG_BIT] && !(wr && a == `OFS_CTRL_FLAGS)) |=> ctrl_q[`CTRL_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("event flag lost");
  property p_irq_module;
    @(posedge clk_i) disable iff (!nrst_i)
      (ctrl_q[`CTRL_FLAG_BIT] && mode_q[`MODE_IRQ_EN_BIT]) |-> irq_o;
  endproperty
  a_irq_module: assert property (p_irq_module) else $error("module request missing");
  property p_cnt_step;
    @(posedge clk_i) disable iff (!nrst_i)
      (ctrl_q[`CTRL_RUN_BIT] && tick && !(wr && a[7:1] == 7'h6f)) |=>
        cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");
  property p_reload_at_ovf;
    @(posedge clk_i) disable iff (!nrst_i)
      (ovf && wave_mode) |=> cmp_q == $past(shadow_q);
  endproperty
  a_reload_at_ovf: assert property (p_reload_at_ovf) else $error("shadow not loaded");
  property p_shadow_kept;
    @(posedge clk_i) disable iff (!nrst_i)
      (wr && (a == `OFS_CMP_LO || a == `OFS_CMP_HI) && !wcfg_q[`WCFG_RELOAD_BIT]) |=>
        $stable(shadow_q);
  endproperty
  a_shadow_kept: assert property (p_shadow_kept) else $error("shadow written directly");
  property p_cmp_kept;
    @(posedge clk_i) disable iff (!nrst_i)
      (wr && (a == `OFS_CMP_LO || a == `OFS_CMP_HI) && wcfg_q[`WCFG_RELOAD_BIT] && !ovf) |=>
        $stable(cmp_q);
  endproperty
  a_cmp_kept: assert property (p_cmp_kept) else $error("compare changed mid period");
  property p_sys_tick;
    @(posedge clk_i) disable iff (!nrst_i) (tb_sel == TB_SYS) |-> tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system tick missing");
  // divider restarts on each tick, so the next cycle is quiet
  sequence s_div4_tick;
    tb_sel == TB_DIV4 && tick;
  endsequence
  sequence s_div4_held;
    tb_sel == TB_DIV4;
  endsequence
  property p_div4_gap;
    @(posedge clk_i) disable iff (!nrst_i) s_div4_tick ##1 s_div4_held |-> !tick;
  endproperty
  a_div4_gap: assert property (p_div4_gap) else $error("divide by four too fast");
  property p_no_reserved_tick;
    @(posedge clk_i) disable iff (!nrst_i) (tb_q[`TB_SEL_LSB +: 3] >= 3'h6) |-> !tick;
  endproperty
  a_no_reserved_tick: assert property (p_no_reserved_tick) else $error("reserved tick");
  property p_full_duty;
    @(posedge clk_i) disable iff (!nrst_i)
      (wave_mode && cmp_q == 16'h0000 && module_output_pin_o) |=> module_output_pin_o;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty broken");
endmodule

/* File: rtl/pwm16_consts.svh */
// register offsets, field positions, reset values and divider limits
`ifndef PWM16_CONSTS_SVH
`define PWM16_CONSTS_SVH
`define OFS_CTRL_FLAGS 8'hd8
`define OFS_TIMEBASE 8'hd9
`define OFS_MODE 8'hda
`define OFS_CMP_LO 8'hdb
`define OFS_CMP_HI 8'hdc
`define OFS_WAVE_CFG 8'hdd
`define OFS_COUNT_LO 8'hde
`define OFS_COUNT_HI 8'hdf
`define CTRL_OVF_BIT 7
`define CTRL_RUN_BIT 6
`define CTRL_FLAG_BIT 0
`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'hc1
`define MODE_CMP_EN_BIT 6
`define MODE_MATCH_BIT 3
`define MODE_WAVE_BIT 1
`define MODE_IRQ_EN_BIT 0
`define MODE_SIXTEEN_BIT 7
`define MODE_RESET 8'h00
`define WCFG_RELOAD_BIT 7
`define TB_IRQ_EN_BIT 0
`define TB_SEL_LSB 1
`define DIV12 4'hb
`define DIV4 4'h3
`define DIV8 4'h7
`endif

/* File: rtl/pwm16_pkg.sv */
// types shared by the waveform block
package pwm16_pkg;
  typedef enum logic [2:0] {
    TB_DIV12 = 3'h0,
    TB_DIV4 = 3'h1,
    TB_T0 = 3'h2,
    TB_FALL = 3'h3,
    TB_SYS = 3'h4,
    TB_EXT8 = 3'h5
  } timebase_t;
endpackage
